// ===== verif/fss_sweep_seq_props.sv
// Port checks of the sweep sequencer
`include "fss_regs.svh"
module fss_sweep_seq_props
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic instrument_trigger_input_i,
   input wire logic pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic [31:0] freq_o,
   input wire logic sweep_running_o,
   input wire logic freq_sweep_en_o,
   input wire logic level_sweep_en_o,
   input wire logic lf_sweep_en_o,
   input wire logic list_mode_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_access_start;
      psel_i && penable_i && !pready_o && !$past(penable_i);
   endsequence
   sequence s_en_write;
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == `FSS_ADDR_EN;
   endsequence
   a_ready_delay: assert property (s_access_start |=> pready_o)
      else $error("ready missed the single wait state");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_ready_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside an access");
   a_err_unmapped: assert property (pready_o && paddr_i > `FSS_ADDR_FREQ |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (pready_o && paddr_i <= `FSS_ADDR_FREQ && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
      else $error("mapped access refused");
   a_bus_quiet: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
      else $error("read data or error outside ready");
   a_one_sweep: assert property ($onehot0({list_mode_en_o, lf_sweep_en_o, level_sweep_en_o, freq_sweep_en_o}))
      else $error("more than one sweep type enabled");
   a_run_enabled: assert property (sweep_running_o |-> freq_sweep_en_o)
      else $error("sweep runs while disabled");
   a_en_lowest: assert property (s_en_write ##0 pwdata_i[3:0] == 4'he |=> ##[0:1] level_sweep_en_o && !freq_sweep_en_o)
      else $error("enable write did not keep the lowest bit");
endmodule : fss_sweep_seq_props

bind fss_sweep_seq fss_sweep_seq_props fss_sweep_seq_props_i
(
   .ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .instrument_trigger_input_i,
   .pready_o, .prdata_o, .pslverr_o, .freq_o, .sweep_running_o, .freq_sweep_en_o, .level_sweep_en_o,
   .lf_sweep_en_o, .list_mode_en_o
);

// ===== verif/fss_trig_src.sv
// External trigger source model for the sweep sequencer bench
module fss_trig_src
#(
   parameter int unsigned HOLD_CYC = 3
)
(
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic idle_lvl_i,
   output logic trig_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_ff = 8'h00;
   // Each level lasts HOLD_CYC cycles, long enough for the synchroniser
   always @(posedge clk_i)
   begin
      if (fire_i && cnt_ff == 8'h00)
         cnt_ff <= 8'(2 * HOLD_CYC);
      else if (cnt_ff != 8'h00)
         cnt_ff <= cnt_ff - 8'h01;
   end
   // Pulse is the inverse of the idle level, so polarity follows idle_lvl_i
   assign trig_o = idle_lvl_i ^ (cnt_ff > 8'(HOLD_CYC));
endmodule : fss_trig_src

// ===== verif/tb_fss_sweep_seq.sv
// Self-checking bench of the sweep sequencer
`include "fss_regs.svh"
module tb_fss_sweep_seq;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic trig_fire = 1'b0;
   logic idle_lvl = 1'b0;
   logic instrument_trigger_input_i, pready_o, pslverr_o, sweep_running_o;
   logic freq_sweep_en_o, level_sweep_en_o, lf_sweep_en_o, list_mode_en_o;
   logic [31:0] prdata_o, freq_o, rd_data, en_all, keep;
   logic rd_err;
   logic [31:0] exp_q[$];
   int fail_count = 0;
   int checks_done = 0;
   assign en_all = {28'h0, list_mode_en_o, lf_sweep_en_o, level_sweep_en_o, freq_sweep_en_o};
   always #4 ref_clk_i = ~ref_clk_i;
   fss_sweep_seq fss_sweep_seq_i
   (
      .ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .instrument_trigger_input_i,
      .pready_o, .prdata_o, .pslverr_o, .freq_o, .sweep_running_o, .freq_sweep_en_o, .level_sweep_en_o,
      .lf_sweep_en_o, .list_mode_en_o
   );
   fss_trig_src fss_trig_src_i
   (
      .clk_i(ref_clk_i), .fire_i(trig_fire), .idle_lvl_i(idle_lvl), .trig_o(instrument_trigger_input_i)
   );
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready_o !== 1'b1);
      rd_data = prdata_o;
      rd_err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // One wait state: ready is seen at the second access edge
      chk("ready wait", n, 32'h2);
   endtask : apb
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd_data, exp);
   endtask : rd_chk
   task automatic cmd(input int b);
      apb(1'b1, `FSS_ADDR_CMD, 32'h1 << b);
      repeat (4) @(posedge ref_clk_i);
   endtask : cmd
   task automatic pulse(input int settle);
      @(posedge ref_clk_i);
      trig_fire <= 1'b1;
      @(posedge ref_clk_i);
      trig_fire <= 1'b0;
      repeat (settle) @(posedge ref_clk_i);
   endtask : pulse
   // Records each change of the output value, so step timing need not be guessed
   task automatic collect(input string what, input int cyc);
      logic [31:0] seen[$];
      seen = {freq_o};
      repeat (cyc)
      begin
         @(posedge ref_clk_i);
         if (freq_o !== seen[$])
            seen.push_back(freq_o);
      end
      chk(what, seen.size(), exp_q.size());
      foreach (exp_q[k])
         chk(what, seen[k], exp_q[k]);
   endtask : collect
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("freq", freq_o, `FSS_RST_START);
      chk("enables", en_all, 32'h0);
      rd_chk("start", `FSS_ADDR_START, `FSS_RST_START);
      rd_chk("stop", `FSS_ADDR_STOP, `FSS_RST_STOP);
      rd_chk("log", `FSS_ADDR_LOG, {16'h0, `FSS_RST_LOG});
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {31'h0, rd_err}, 32'h1);
      apb(1'b1, `FSS_ADDR_EN, 32'he);
      repeat (2) @(posedge ref_clk_i);
      chk("enables", en_all, 32'h2);
      apb(1'b1, `FSS_ADDR_EN, 32'h1);
      repeat (2) @(posedge ref_clk_i);
      chk("enables", en_all, 32'h1);
   endtask : t_reset
   task automatic t_manual;
      apb(1'b1, `FSS_ADDR_START, 32'd100);
      apb(1'b1, `FSS_ADDR_STOP, 32'd400);
      apb(1'b1, `FSS_ADDR_LIN, 32'd100);
      apb(1'b1, `FSS_ADDR_DWELL, 32'h1);
      apb(1'b1, `FSS_ADDR_CTRL, 32'h22);
      repeat (4) @(posedge ref_clk_i);
      chk("manual load", freq_o, 32'd100);
      cmd(`FSS_CMD_DOWN);
      chk("low edge", freq_o, 32'd100);
      for (int k = 2; k <= 4; k++)
      begin
         cmd(`FSS_CMD_UP);
         chk("step up", freq_o, 32'(100 * k));
      end
      cmd(`FSS_CMD_UP);
      chk("high edge", freq_o, 32'd400);
      cmd(`FSS_CMD_DOWN);
      chk("step down", freq_o, 32'd300);
      cmd(`FSS_CMD_RESET);
      chk("reset cmd", freq_o, 32'd100);
      cmd(`FSS_CMD_EXEC);
      chk("exec ignored", {31'h0, sweep_running_o}, 32'h0);
   endtask : t_manual
   task automatic t_ext;
      apb(1'b1, `FSS_ADDR_CTRL, 32'h23);
      repeat (4) @(posedge ref_clk_i);
      chk("ext load", freq_o, 32'd100);
      exp_q = '{32'd100, 32'd200, 32'd300, 32'd400};
      pulse(0);
      collect("ext single", 800);
      exp_q = '{32'd400, 32'd100, 32'd200, 32'd300, 32'd400};
      pulse(0);
      collect("ext again", 800);
      apb(1'b1, `FSS_ADDR_CTRL, 32'h25);
      repeat (4) @(posedge ref_clk_i);
      chk("ss load", freq_o, 32'd100);
      pulse(12);
      chk("ss run", {31'h0, sweep_running_o}, 32'h1);
      repeat (200) @(posedge ref_clk_i);
      pulse(12);
      keep = freq_o;
      chk("ss stop", {31'h0, sweep_running_o}, 32'h0);
      repeat (300) @(posedge ref_clk_i);
      chk("ss frozen", freq_o, keep);
      pulse(12);
      chk("ss restart", freq_o, 32'd100);
      chk("ss rerun", {31'h0, sweep_running_o}, 32'h1);
      pulse(12);
      chk("ss stop again", {31'h0, sweep_running_o}, 32'h0);
      // Falling polarity: raising the idle level is an ignored edge
      apb(1'b1, `FSS_ADDR_CTRL, 32'h04);
      @(posedge ref_clk_i);
      idle_lvl <= 1'b1;
      repeat (12) @(posedge ref_clk_i);
      chk("rise ignored", freq_o, 32'd100);
      pulse(12);
      chk("ext step", freq_o, 32'd200);
   endtask : t_ext
   task automatic t_log;
      apb(1'b1, `FSS_ADDR_START, 32'd1000);
      apb(1'b1, `FSS_ADDR_STOP, 32'd1400);
      apb(1'b1, `FSS_ADDR_LOG, 32'd1000);
      apb(1'b1, `FSS_ADDR_CTRL, 32'h2a);
      cmd(`FSS_CMD_RESET);
      chk("log load", freq_o, 32'd1000);
      exp_q = '{32'd1100, 32'd1210, 32'd1331, 32'd1400};
      foreach (exp_q[k])
      begin
         cmd(`FSS_CMD_UP);
         chk("log step", freq_o, exp_q[k]);
      end
      apb(1'b1, `FSS_ADDR_STOP, 32'd1331);
      apb(1'b1, `FSS_ADDR_CTRL, 32'h39);
      repeat (4) @(posedge ref_clk_i);
      exp_q = '{32'd1000, 32'd1100, 32'd1210, 32'd1331, 32'd1210, 32'd1100, 32'd1000};
      apb(1'b1, `FSS_ADDR_CMD, 32'h1 << `FSS_CMD_EXEC);
      collect("triangle", 1200);
      chk("single ends", {31'h0, sweep_running_o}, 32'h0);
   endtask : t_log
   // Auto sawtooth with linear step 100 between 1000 and 1331
   task automatic t_auto;
      apb(1'b1, `FSS_ADDR_CTRL, 32'h20);
      cmd(`FSS_CMD_RESET);
      exp_q = '{32'd1000, 32'd1100, 32'd1200, 32'd1300, 32'd1331, 32'd1000};
      collect("auto sawtooth", 700);
      chk("auto runs", {31'h0, sweep_running_o}, 32'h1);
   endtask : t_auto
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_reset();
      $display("reset test done");
      t_manual();
      $display("manual test done");
      t_ext();
      $display("trigger test done");
      t_log();
      $display("log test done");
      t_auto();
      $display("auto test done");
      close_out();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      $display("Error watchdog expected finish seen hang");
      close_out();
   end
endmodule : tb_fss_sweep_seq

// ===== verilog/fss_pkg.sv
// Types shared by the sweep sequencer
package fss_pkg;

   // ----------------------------------------
   // Sweep modes and sequencer states
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      FSS_MODE_AUTO = 3'h0,
      FSS_MODE_SINGLE = 3'h1,
      FSS_MODE_MANUAL = 3'h2,
      FSS_MODE_EXT_SINGLE = 3'h3,
      FSS_MODE_EXT_STEP = 3'h4,
      FSS_MODE_EXT_SS = 3'h5
   } fss_mode_t;

   typedef enum logic [2:0]
   {
      FSS_ST_IDLE = 3'b001,
      FSS_ST_RUN = 3'b010,
      FSS_ST_FROZEN = 3'b100
   } fss_state_t;

endpackage : fss_pkg

// ===== verilog/fss_regs.svh
// Register map, field positions, reset values and timing counts of the sweep sequencer
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define FSS_ADDR_CTRL 8'h00
`define FSS_ADDR_EN 8'h04
`define FSS_ADDR_CMD 8'h08
`define FSS_ADDR_START 8'h0c
`define FSS_ADDR_STOP 8'h10
`define FSS_ADDR_LIN 8'h14
`define FSS_ADDR_LOG 8'h18
`define FSS_ADDR_DWELL 8'h1c
`define FSS_ADDR_STAT 8'h20
`define FSS_ADDR_FREQ 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSS_CTRL_SPACING 3
`define FSS_CTRL_SHAPE 4
`define FSS_CTRL_TRIGPOL 5
`define FSS_CMD_EXEC 0
`define FSS_CMD_RESET 1
`define FSS_CMD_UP 2
`define FSS_CMD_DOWN 3
`define FSS_EN_FREQ 0
`define FSS_EN_LEVEL 1
`define FSS_EN_LF 2
`define FSS_EN_LIST 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSS_RST_START 32'h05f5_e100
`define FSS_RST_STOP 32'h1dcd_6500
`define FSS_RST_LIN 32'h0098_9680
`define FSS_RST_LOG 16'h0064
`define FSS_RST_DWELL 16'h000a

// ----------------------------------------
// Timing and arithmetic
// ----------------------------------------
`define FSS_CLK_PERIOD_NS 8
`define FSS_NS_PER_US 1000
`define FSS_CYC_PER_US (`FSS_NS_PER_US / `FSS_CLK_PERIOD_NS)
`define FSS_LOG_DEN 64'h0000_0000_0000_2710
`define FSS_GRID_MAX 8'hff

`endif

// ===== verilog/fss_sweep_seq.sv
// Frequency sweep sequencer with APB register access and external trigger
//
// Behaviour
// R1 - Entering manual step mode loads start frequency before any step.
// R2 - Up moves to next higher grid point, down to next lower.
// R3 - At start or stop boundary, steps leaving the range are ignored.
// R4 - External single runs one sweep per trigger, always from start.
// R5 - Switching into triggered modes halts sweep; next run begins at start.
// R6 - External step advances one configured step per trigger.
// R7 - Start/stop: first trigger runs repeating sweep, second freezes it.
// R8 - Start/stop: third trigger restarts from start, then alternation continues.
// R9 - Execute command launches a sweep only in single mode.
// R10 - Reset command sets start frequency; next sweep proceeds from there.
// R11 - Linear spacing adds fixed hertz step to present frequency.
// R12 - Log spacing multiplies or divides by (1+step/100), clamped to stop. The code uses (1+step/10000).
// R13 - Sawtooth runs start to stop, next sweep again from start.
// R14 - Triangle runs start to stop and back, next sweep from start.
// R15 - Triangle return slope revisits exactly the forward grid points.
// R16 - Step width governs stepping in every sweep mode.
// R17 - Dwell time is the full step period, settling included.
// R18 - Enabling one sweep type or list mode disables all others.
// R19 - Trigger input synchronised, one event per edge of selectable polarity.
`include "fss_regs.svh"

module fss_sweep_seq
   import fss_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic instrument_trigger_input_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   output logic [31:0] freq_o,
   output logic sweep_running_o,
   output logic freq_sweep_en_o,
   output logic level_sweep_en_o,
   output logic lf_sweep_en_o,
   output logic list_mode_en_o
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [3:0] fss_lowest(input logic [3:0] x);
      fss_lowest = x & (~x + 4'h1);
   endfunction : fss_lowest

   function automatic logic [31:0] fss_next_f(
      input logic [31:0] f,
      input logic [31:0] stp,
      input logic up,
      input logic lg,
      input logic [31:0] lin,
      input logic [15:0] lgw
   );
      logic [63:0] fw;
      logic [63:0] t;
      fw = {32'h0, f};
      t = fw;
      if (lg && up)
      begin
         t = fw + (fw * {48'h0, lgw}) / `FSS_LOG_DEN;
         if (t == fw)
            t = fw + 64'h1;
      end
      else if (lg)
      begin
         t = (fw * `FSS_LOG_DEN) / (`FSS_LOG_DEN + {48'h0, lgw});
         if (t == fw && fw != 64'h0)
            t = fw - 64'h1;
      end
      else if (up)
         t = fw + {32'h0, lin};
      else if (lin > f)
         t = 64'h0;
      else
         t = fw - {32'h0, lin};
      if (up && t > {32'h0, stp})
         t = {32'h0, stp};
      if (!up && t < {32'h0, stp})
         t = {32'h0, stp};
      fss_next_f = t[31:0];
   endfunction : fss_next_f

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   fss_mode_t mode_ff;
   fss_state_t state_ff;
   fss_state_t nxt_state;
   logic log_sp_ff;
   logic tri_ff;
   logic trig_rise_ff;
   logic [3:0] en_ff;
   logic [31:0] start_ff;
   logic [31:0] stop_ff;
   logic [31:0] lin_ff;
   logic [15:0] log_ff;
   logic [15:0] dwell_ff;
   logic [31:0] freq_ff;
   logic [31:0] nxt_freq;
   logic [7:0] idx_ff;
   logic [7:0] nxt_idx;
   logic dir_down_ff;
   logic nxt_dir;
   logic [23:0] cnt_ff;
   logic [23:0] nxt_cnt;
   logic trig_meta_ff;
   logic trig_sync_ff;
   logic trig_prev_ff;
   logic pready_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic [31:0] grid_mem [0:255];
   logic grid_we;
   logic [7:0] grid_wa;
   logic [31:0] grid_wd;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire acc_done = psel_i & penable_i & pready_ff;
   wire wr = acc_done & pwrite_i;
   wire sel_ctrl = paddr_i == `FSS_ADDR_CTRL;
   wire sel_en = paddr_i == `FSS_ADDR_EN;
   wire sel_cmd = paddr_i == `FSS_ADDR_CMD;
   wire sel_start = paddr_i == `FSS_ADDR_START;
   wire sel_stop = paddr_i == `FSS_ADDR_STOP;
   wire sel_lin = paddr_i == `FSS_ADDR_LIN;
   wire sel_log = paddr_i == `FSS_ADDR_LOG;
   wire sel_dwell = paddr_i == `FSS_ADDR_DWELL;
   wire sel_stat = paddr_i == `FSS_ADDR_STAT;
   wire sel_freq = paddr_i == `FSS_ADDR_FREQ;
   wire mapped = sel_ctrl | sel_en | sel_cmd | sel_start | sel_stop | sel_lin | sel_log | sel_dwell
                 | sel_stat | sel_freq;
   wire [31:0] rd_data = sel_ctrl ? {26'h0, trig_rise_ff, tri_ff, log_sp_ff, mode_ff} :
                         sel_en ? {28'h0, en_ff} :
                         sel_start ? start_ff :
                         sel_stop ? stop_ff :
                         sel_lin ? lin_ff :
                         sel_log ? {16'h0, log_ff} :
                         sel_dwell ? {16'h0, dwell_ff} :
                         sel_stat ? {20'h0, state_ff, dir_down_ff, idx_ff} :
                         sel_freq ? freq_ff : 32'h0;

   // ----------------------------------------
   // Commands and mode changes
   // ----------------------------------------
   wire cmd_wr = wr & sel_cmd;
   wire cmd_exec = cmd_wr & pwdata_i[`FSS_CMD_EXEC];
   wire cmd_reset = cmd_wr & pwdata_i[`FSS_CMD_RESET];
   wire cmd_up = cmd_wr & pwdata_i[`FSS_CMD_UP];
   wire cmd_down = cmd_wr & pwdata_i[`FSS_CMD_DOWN];
   wire [2:0] wr_mode = pwdata_i[2:0];
   wire mode_chg = wr & sel_ctrl & (wr_mode != mode_ff);
   wire [3:0] en_wr = fss_lowest(pwdata_i[3:0]);
   wire en_rise = wr & sel_en & en_wr[`FSS_EN_FREQ] & ~en_ff[`FSS_EN_FREQ];
   // Stop in the same edge the enable drops, so running never outlives it
   wire en_off = wr & sel_en & ~en_wr[`FSS_EN_FREQ];
   wire active = en_ff[`FSS_EN_FREQ];
   wire halt = mode_chg | en_rise;
   // Auto resumes from the present setting; every other mode restarts
   wire halt_mode_auto = mode_chg ? (wr_mode == FSS_MODE_AUTO) : (mode_ff == FSS_MODE_AUTO);

   // ----------------------------------------
   // Trigger edge detect
   // ----------------------------------------
   wire trig_evt = trig_rise_ff ? (trig_sync_ff & ~trig_prev_ff) : (~trig_sync_ff & trig_prev_ff); // [R19]

   // ----------------------------------------
   // Sweep grid arithmetic
   // ----------------------------------------
   wire up_dir = start_ff <= stop_ff;
   wire [31:0] fwd_f = fss_next_f(freq_ff, stop_ff, up_dir, log_sp_ff, lin_ff, log_ff); // [R11] [R12] [R16]
   // Return steps replay stored points, so log rounding cannot drift
   wire [31:0] back_f = grid_mem[idx_ff - 8'h1]; // [R15]
   // Grid depth caps one slope at 256 points
   wire at_stop = (freq_ff == stop_ff) | (idx_ff == `FSS_GRID_MAX);
   wire [23:0] dwell_cyc = 24'(dwell_ff * `FSS_CYC_PER_US);
   wire [23:0] dwell_rld = (dwell_cyc == 24'h0) ? 24'h0 : dwell_cyc - 24'h1;
   wire tick = (state_ff == FSS_ST_RUN) & (cnt_ff == 24'h0); // [R17]
   wire one_shot = (mode_ff == FSS_MODE_SINGLE) | (mode_ff == FSS_MODE_EXT_SINGLE);
   wire adv_fwd = ~dir_down_ff & ~at_stop;
   wire adv_turn = ~dir_down_ff & at_stop & tri_ff & (idx_ff != 8'h0);
   wire adv_back = dir_down_ff & (idx_ff > 8'h1);
   wire adv_home = dir_down_ff & (idx_ff <= 8'h1);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic do_adv;
   logic do_load;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_freq = freq_ff;
      nxt_idx = idx_ff;
      nxt_dir = dir_down_ff;
      nxt_cnt = (cnt_ff == 24'h0) ? dwell_rld : cnt_ff - 24'h1;
      do_adv = 1'b0;
      do_load = 1'b0;
      if (!active || en_off)
         nxt_state = FSS_ST_IDLE; // [R18]
      else if (halt)
      begin
         do_load = ~halt_mode_auto; // [R1] [R5]
         nxt_state = halt_mode_auto ? FSS_ST_RUN : FSS_ST_IDLE;
      end
      else if (cmd_reset)
         do_load = 1'b1; // [R10]
      else
      begin
         case (mode_ff)
            FSS_MODE_AUTO:
            begin
               nxt_state = FSS_ST_RUN;
               do_adv = tick;
            end
            FSS_MODE_SINGLE:
            begin
               if (cmd_exec) // [R9]
               begin
                  do_load = 1'b1;
                  nxt_state = FSS_ST_RUN;
               end
               else
                  do_adv = tick;
            end
            FSS_MODE_MANUAL:
            begin
               nxt_state = FSS_ST_IDLE;
               if (cmd_up && !at_stop) // [R2] [R3]
               begin
                  nxt_freq = fwd_f;
                  nxt_idx = idx_ff + 8'h1;
                  nxt_dir = 1'b0;
               end
               else if (cmd_down && idx_ff != 8'h0) // [R2] [R3]
               begin
                  nxt_freq = back_f;
                  nxt_idx = idx_ff - 8'h1;
               end
            end
            FSS_MODE_EXT_SINGLE:
            begin
               if (trig_evt && state_ff == FSS_ST_IDLE) // [R4]
               begin
                  do_load = 1'b1;
                  nxt_state = FSS_ST_RUN;
               end
               else
                  do_adv = tick;
            end
            FSS_MODE_EXT_STEP:
            begin
               nxt_state = FSS_ST_IDLE;
               do_adv = trig_evt; // [R6]
            end
            FSS_MODE_EXT_SS:
            begin
               if (trig_evt && state_ff == FSS_ST_RUN)
                  nxt_state = FSS_ST_FROZEN; // [R7]
               else if (trig_evt)
               begin
                  do_load = 1'b1; // [R7] [R8]
                  nxt_state = FSS_ST_RUN;
               end
               else
                  do_adv = tick;
            end
            default:
               nxt_state = FSS_ST_IDLE;
         endcase
      end
      if (do_adv)
      begin
         if (adv_fwd)
         begin
            nxt_freq = fwd_f;
            nxt_idx = idx_ff + 8'h1;
         end
         else if (adv_turn || adv_back) // [R14]
         begin
            nxt_dir = 1'b1;
            nxt_freq = back_f;
            nxt_idx = idx_ff - 8'h1;
         end
         else if (adv_home)
         begin
            nxt_dir = 1'b0;
            nxt_freq = grid_mem[8'h0];
            nxt_idx = 8'h0;
            if (one_shot)
               nxt_state = FSS_ST_IDLE;
         end
         else if (one_shot)
            nxt_state = FSS_ST_IDLE;
         else
            do_load = 1'b1; // [R13]
      end
      if (do_load)
      begin
         nxt_freq = start_ff;
         nxt_idx = 8'h0;
         nxt_dir = 1'b0;
         nxt_cnt = dwell_rld;
      end
   end

   assign grid_we = do_load | (nxt_idx == idx_ff + 8'h1);
   assign grid_wa = nxt_idx;
   assign grid_wd = nxt_freq;

   // ----------------------------------------
   // Clocked state
   // ----------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (grid_we)
         grid_mem[grid_wa] <= grid_wd;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= FSS_ST_IDLE;
         freq_ff <= `FSS_RST_START;
         idx_ff <= 8'h0;
         dir_down_ff <= 1'b0;
         cnt_ff <= 24'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         freq_ff <= nxt_freq;
         idx_ff <= nxt_idx;
         dir_down_ff <= nxt_dir;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         trig_meta_ff <= 1'b0;
         trig_sync_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
      end
      else
      begin
         trig_meta_ff <= instrument_trigger_input_i; // [R19]
         trig_sync_ff <= trig_meta_ff;
         trig_prev_ff <= trig_sync_ff;
      end
   end

   // ----------------------------------------
   // APB slave, one wait state
   // ----------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= psel_i & penable_i & ~pready_ff;
         prdata_ff <= (psel_i & penable_i & ~pready_ff & ~pwrite_i) ? rd_data : 32'h0;
         pslverr_ff <= psel_i & penable_i & ~pready_ff & ~mapped;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         mode_ff <= FSS_MODE_AUTO;
         log_sp_ff <= 1'b0;
         tri_ff <= 1'b0;
         trig_rise_ff <= 1'b1;
         en_ff <= 4'h0;
         start_ff <= `FSS_RST_START;
         stop_ff <= `FSS_RST_STOP;
         lin_ff <= `FSS_RST_LIN;
         log_ff <= `FSS_RST_LOG;
         dwell_ff <= `FSS_RST_DWELL;
      end
      else
      begin
         if (wr && sel_ctrl)
         begin
            mode_ff <= fss_mode_t'(wr_mode);
            log_sp_ff <= pwdata_i[`FSS_CTRL_SPACING];
            tri_ff <= pwdata_i[`FSS_CTRL_SHAPE];
            trig_rise_ff <= pwdata_i[`FSS_CTRL_TRIGPOL];
         end
         if (wr && sel_en)
            en_ff <= en_wr; // [R18]
         if (wr && sel_start)
            start_ff <= pwdata_i;
         if (wr && sel_stop)
            stop_ff <= pwdata_i;
         if (wr && sel_lin)
            lin_ff <= pwdata_i;
         if (wr && sel_log)
            log_ff <= pwdata_i[15:0];
         if (wr && sel_dwell)
            dwell_ff <= pwdata_i[15:0];
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign pready_o = pready_ff;
   assign prdata_o = prdata_ff;
   assign pslverr_o = pslverr_ff;
   assign freq_o = freq_ff;
   assign sweep_running_o = state_ff[1];
   assign freq_sweep_en_o = en_ff[`FSS_EN_FREQ];
   assign level_sweep_en_o = en_ff[`FSS_EN_LEVEL];
   assign lf_sweep_en_o = en_ff[`FSS_EN_LF];
   assign list_mode_en_o = en_ff[`FSS_EN_LIST];

endmodule : fss_sweep_seq
